// ==== hw/digital_input_channel_router.sv ====
// digital input channel router with apb register slave
// What this block does
// RQ1: selector 0..32; 0 unused, 1-4 basic functions
// RQ2: values 5 to 12 route clamp through vibration
// RQ3: 13-15 speed bits, 16 none, 17 mixed
// RQ4: 20 segment enable, 21-24 segment bits
// RQ5: polarity 0 active low, 1 active high
// RQ6: source 0 terminal, 1 virtual input
// RQ7: machine fault always gives free shutdown
// RQ8: controller drops enable once motor stopped; no motor-stopped logic here, servo_enable_in just follows the channel
// RQ9: inhibit zeroes speed in blocked direction only
// RQ10: synchronise, then polarity, then route function
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module digital_input_channel_router
  import di_router_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  // terminal and drive state
  input  wire logic                input_channel_four,
  input  wire logic                machine_fault,
  input  wire logic                speed_dir_fwd,
  // routed function signals
  output logic                     servo_enable_in,
  output logic                     fault_warning_clear,
  output logic                     forward_drive_inhibit,
  output logic                     reverse_drive_inhibit,
  output logic                     zero_speed_hold,
  output logic                     deviation_counter_clear,
  output logic                     command_inversion,
  output logic                     emergency_stop,
  output logic                     gear_switch,
  output logic                     gain_switch,
  output logic                     command_pulse_inhibit,
  output logic                     vibration_control_switch,
  output logic                     speed_select_bit1,
  output logic                     speed_select_bit2,
  output logic                     speed_select_bit3,
  output logic                     mixed_mode_choice,
  output logic                     segment_enable,
  output logic      [SEG_BITS-1:0] segment_select,
  // drive outcome
  output logic                     torque_off,
  output logic                     speed_force_zero
);

  logic [SEL_W-1:0] func_sel_q;
  logic [SEL_W-1:0] pol_sel_q;
  logic [SEL_W-1:0] src_sel_q;
  logic             virtual_input_four_q;
  logic             term_meta_q;
  logic             term_sync_q;
  logic             fault_meta_q;
  logic             fault_sync_q;
  logic             raw_level;
  logic             active;
  logic             wr_en;
  logic             any_routed;
  logic             addr_ok;

  // zero wait states; every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = (paddr == FUNC_SEL_ADDR) || (paddr == POL_SEL_ADDR) ||
                   (paddr == SRC_SEL_ADDR) || (paddr == VIRT_IN_ADDR) ||
                   (paddr == STATUS_ADDR);
  assign pslverr = psel && penable && !addr_ok;

  // register writes; out-of-range selector values are still stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_sel_q           <= FUNC_SEL_RST;
      pol_sel_q            <= POL_SEL_RST;
      src_sel_q            <= SRC_SEL_RST;
      virtual_input_four_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        FUNC_SEL_ADDR: func_sel_q           <= pwdata[SEL_W-1:0]; // RQ1
        POL_SEL_ADDR:  pol_sel_q            <= pwdata[SEL_W-1:0];
        SRC_SEL_ADDR:  src_sel_q            <= pwdata[SEL_W-1:0];
        VIRT_IN_ADDR:  virtual_input_four_q <= pwdata[0];
        default:       func_sel_q           <= func_sel_q;
      endcase
    end
  end

  // read data from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        FUNC_SEL_ADDR: prdata <= {16'h0000, func_sel_q};
        POL_SEL_ADDR:  prdata <= {16'h0000, pol_sel_q};
        SRC_SEL_ADDR:  prdata <= {16'h0000, src_sel_q};
        VIRT_IN_ADDR:  prdata <= {31'h0000_0000, virtual_input_four_q};
        STATUS_ADDR:   prdata <= {29'h0000_0000, fault_sync_q, raw_level, active};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // two-stage synchronisers for terminal and fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // idle level of the pulled-up pin, so no false function after reset
      term_meta_q  <= 1'b1;
      term_sync_q  <= 1'b1;
      fault_meta_q <= 1'b0;
      fault_sync_q <= 1'b0;
    end
    else
    begin
      term_meta_q  <= input_channel_four; // RQ10
      term_sync_q  <= term_meta_q;
      fault_meta_q <= machine_fault;
      fault_sync_q <= fault_meta_q;
    end
  end

  // source then polarity; virtual input is already on pclk
  assign raw_level = src_sel_q[0] ? virtual_input_four_q : term_sync_q; // RQ6
  assign active    = pol_sel_q[0] ? raw_level : !raw_level; // RQ5

  // function routing, registered; unmatched codes drive nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      servo_enable_in          <= 1'b0;
      fault_warning_clear      <= 1'b0;
      forward_drive_inhibit    <= 1'b0;
      reverse_drive_inhibit    <= 1'b0;
      zero_speed_hold          <= 1'b0;
      deviation_counter_clear  <= 1'b0;
      command_inversion        <= 1'b0;
      emergency_stop           <= 1'b0;
      gear_switch              <= 1'b0;
      gain_switch              <= 1'b0;
      command_pulse_inhibit    <= 1'b0;
      vibration_control_switch <= 1'b0;
      speed_select_bit1        <= 1'b0;
      speed_select_bit2        <= 1'b0;
      speed_select_bit3        <= 1'b0;
      mixed_mode_choice        <= 1'b0;
      segment_enable           <= 1'b0;
    end
    else
    begin
      servo_enable_in          <= active && (func_sel_q == FN_SERVO_EN); // RQ1
      fault_warning_clear      <= active && (func_sel_q == FN_FAULT_CLR); // RQ1
      forward_drive_inhibit    <= active && (func_sel_q == FN_FWD_BLOCK); // RQ1
      reverse_drive_inhibit    <= active && (func_sel_q == FN_REV_BLOCK); // RQ1
      zero_speed_hold          <= active && (func_sel_q == FN_ZERO_HOLD); // RQ2
      deviation_counter_clear  <= active && (func_sel_q == FN_DEV_CLR); // RQ2
      command_inversion        <= active && (func_sel_q == FN_CMD_INV); // RQ2
      emergency_stop           <= active && (func_sel_q == FN_ESTOP); // RQ2
      gear_switch              <= active && (func_sel_q == FN_GEAR_SW); // RQ2
      gain_switch              <= active && (func_sel_q == FN_GAIN_SW); // RQ2
      command_pulse_inhibit    <= active && (func_sel_q == FN_PULSE_BLOCK); // RQ2
      vibration_control_switch <= active && (func_sel_q == FN_VIB_SW); // RQ2
      speed_select_bit1        <= active && (func_sel_q == FN_SPD1); // RQ3
      speed_select_bit2        <= active && (func_sel_q == FN_SPD2); // RQ3
      speed_select_bit3        <= active && (func_sel_q == FN_SPD3); // RQ3
      mixed_mode_choice        <= active && (func_sel_q == FN_MIXED); // RQ3
      segment_enable           <= active && (func_sel_q == FN_SEG_EN); // RQ4
    end
  end

  // one flop per segment bit
  genvar g;
  generate
    for (g = 0; g < SEG_BITS; g++)
    begin : g_seg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          segment_select[g] <= 1'b0;
        else
          segment_select[g] <= active &&
                               (func_sel_q == FN_SEG1 + 16'(g)); // RQ4
      end
    end
  endgenerate

  // fault shutdown is always free: torque removed, no zero-speed lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      torque_off <= 1'b0;
    else
      torque_off <= fault_sync_q || emergency_stop; // RQ7
  end

  // clamp only the blocked direction; the unblocked direction stays free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed_force_zero <= 1'b0;
    else
      speed_force_zero <= (forward_drive_inhibit && speed_dir_fwd) ||
                          (reverse_drive_inhibit && !speed_dir_fwd); // RQ9
  end

  // any function output at all, for the reserved-code checks
  assign any_routed = servo_enable_in || fault_warning_clear || forward_drive_inhibit ||
                      reverse_drive_inhibit || zero_speed_hold || deviation_counter_clear ||
                      command_inversion || emergency_stop || gear_switch || gain_switch ||
                      command_pulse_inhibit || vibration_control_switch || speed_select_bit1 ||
                      speed_select_bit2 || speed_select_bit3 || mixed_mode_choice ||
                      segment_enable || (|segment_select);

  AST_FWD_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (active && func_sel_q == FN_FWD_BLOCK) |=> forward_drive_inhibit)
    else $error("forward inhibit not routed");

  AST_RESERVED_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    ((func_sel_q == FN_OFF) || (func_sel_q == 16'h0012) || (func_sel_q == 16'h0013) ||
     (func_sel_q > FN_SEG4)) |=> !any_routed)
    else $error("reserved code drove a function");

  AST_VIB_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    $rose(vibration_control_switch) |-> $past(func_sel_q) == FN_VIB_SW)
    else $error("vibration switch from wrong code");

  AST_NO_INERTIA: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (func_sel_q == FN_INERTIA) |=> !any_routed)
    else $error("inertia code drove output");

  AST_POLARITY: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (func_sel_q == FN_SERVO_EN && !src_sel_q[0] && pol_sel_q[0] == 1'b0 &&
     !term_sync_q) |=> servo_enable_in)
    else $error("low level not active for polarity 0");

  AST_VIRTUAL: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    (src_sel_q[0] && func_sel_q == FN_SERVO_EN && pol_sel_q[0] &&
     virtual_input_four_q) |=> servo_enable_in)
    else $error("virtual input not routed");

  AST_FAULT_FREE: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    $rose(machine_fault) ##1 machine_fault[*2] |=> torque_off)
    else $error("fault did not remove torque");

  AST_REV_FREE: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (forward_drive_inhibit && !reverse_drive_inhibit && !speed_dir_fwd) |=>
      !speed_force_zero)
    else $error("reverse blocked by forward inhibit");

  AST_SYNC_LAT: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (func_sel_q == FN_ESTOP && !src_sel_q[0] && pol_sel_q[0] &&
     $stable(func_sel_q) && $rose(input_channel_four)) ##2 1 |=> emergency_stop)
    else $error("terminal to function latency wrong");

  AST_ONE_FUNCTION: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    $onehot0({segment_select, segment_enable, mixed_mode_choice, speed_select_bit3,
              speed_select_bit2, speed_select_bit1, vibration_control_switch,
              command_pulse_inhibit, gain_switch, gear_switch, emergency_stop,
              command_inversion, deviation_counter_clear, zero_speed_hold,
              reverse_drive_inhibit, forward_drive_inhibit, fault_warning_clear,
              servo_enable_in}))
    else $error("more than one function driven");

  AST_SPEED_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (active && func_sel_q == FN_SPD1) |=> speed_select_bit1)
    else $error("speed bit 1 not routed");

  AST_SEG_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (active && func_sel_q == FN_SEG4) |=> segment_select[SEG_BITS-1])
    else $error("last segment bit not routed");

  AST_ESTOP_TORQUE: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    emergency_stop |=> torque_off)
    else $error("emergency stop kept torque");

  AST_FWD_CLAMP: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (forward_drive_inhibit && speed_dir_fwd) |=> speed_force_zero)
    else $error("forward motion not clamped");

  AST_POL_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (func_sel_q == FN_SERVO_EN && !src_sel_q[0] && pol_sel_q[0] && term_sync_q) |=>
      servo_enable_in)
    else $error("high level not active for polarity 1");

endmodule // digital_input_channel_router

// ==== inc/di_router_pkg.sv ====
// constants for the digital input channel router
package di_router_pkg;
  // register byte addresses
  localparam logic [11:0] FUNC_SEL_ADDR   = 12'h000;
  localparam logic [11:0] POL_SEL_ADDR    = 12'h004;
  localparam logic [11:0] SRC_SEL_ADDR    = 12'h008;
  localparam logic [11:0] VIRT_IN_ADDR    = 12'h00c;
  localparam logic [11:0] STATUS_ADDR     = 12'h010;
  // register widths and reset values
  localparam int          SEL_W           = 16;
  localparam logic [15:0] FUNC_SEL_RST    = 16'h0004;
  localparam logic [15:0] POL_SEL_RST     = 16'h0000;
  localparam logic [15:0] SRC_SEL_RST     = 16'h0000;
  localparam logic [15:0] FUNC_SEL_MAX    = 16'h0020;
  // status field positions
  localparam int          ST_ACTIVE_BIT   = 0;
  localparam int          ST_RAW_BIT      = 1;
  localparam int          ST_RESERVED_BIT = 2;
  // function selector codes
  localparam logic [15:0] FN_OFF          = 16'h0000;
  localparam logic [15:0] FN_SERVO_EN     = 16'h0001;
  localparam logic [15:0] FN_FAULT_CLR    = 16'h0002;
  localparam logic [15:0] FN_FWD_BLOCK    = 16'h0003;
  localparam logic [15:0] FN_REV_BLOCK    = 16'h0004;
  localparam logic [15:0] FN_ZERO_HOLD    = 16'h0005;
  localparam logic [15:0] FN_DEV_CLR      = 16'h0006;
  localparam logic [15:0] FN_CMD_INV      = 16'h0007;
  localparam logic [15:0] FN_ESTOP        = 16'h0008;
  localparam logic [15:0] FN_GEAR_SW      = 16'h0009;
  localparam logic [15:0] FN_GAIN_SW      = 16'h000a;
  localparam logic [15:0] FN_PULSE_BLOCK  = 16'h000b;
  localparam logic [15:0] FN_VIB_SW       = 16'h000c;
  localparam logic [15:0] FN_SPD1         = 16'h000d;
  localparam logic [15:0] FN_SPD2         = 16'h000e;
  localparam logic [15:0] FN_SPD3         = 16'h000f;
  localparam logic [15:0] FN_INERTIA      = 16'h0010;
  localparam logic [15:0] FN_MIXED        = 16'h0011;
  localparam logic [15:0] FN_SEG_EN       = 16'h0014;
  localparam logic [15:0] FN_SEG1         = 16'h0015;
  localparam logic [15:0] FN_SEG4         = 16'h0018;
  localparam int          SEG_BITS        = 4;
endpackage

// ==== verif/digital_input_channel_router_bench.sv ====
// self-checking bench for the digital input channel router
`timescale 1ns/1ns
module digital_input_channel_router_bench;
  import di_router_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pin, closed, machine_fault, speed_dir_fwd, err;
  logic        servo_en, fclr, fwd, rev, zhold, dclr, cinv, estop, gear, gain, pinh, vib;
  logic        spd1, spd2, spd3, mixed, seg_en, torque_off, speed_force_zero;
  logic [3:0]  seg_sel;
  logic [20:0] routed;
  int          miscompares, total_checks, n;
  logic        pol, src, virt, lvl, act;
  logic [31:0] exp_q[$];
  assign routed = {seg_sel, seg_en, mixed, spd3, spd2, spd1, vib, pinh, gain, gear, estop,
                   cinv, dclr, zhold, rev, fwd, fclr, servo_en};
  always #5 pclk = ~pclk;
  terminal_switch_model terminal_switch_model_inst (.contact_closed(closed), .pin(pin));
  digital_input_channel_router digital_input_channel_router_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .input_channel_four(pin), .machine_fault(machine_fault), .speed_dir_fwd(speed_dir_fwd),
    .servo_enable_in(servo_en), .fault_warning_clear(fclr), .forward_drive_inhibit(fwd),
    .reverse_drive_inhibit(rev), .zero_speed_hold(zhold), .deviation_counter_clear(dclr),
    .command_inversion(cinv), .emergency_stop(estop), .gear_switch(gear),
    .gain_switch(gain), .command_pulse_inhibit(pinh), .vibration_control_switch(vib),
    .speed_select_bit1(spd1), .speed_select_bit2(spd2), .speed_select_bit3(spd3),
    .mixed_mode_choice(mixed), .segment_enable(seg_en), .segment_select(seg_sel),
    .torque_off(torque_off), .speed_force_zero(speed_force_zero));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; waits on pready under a bound
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  function automatic logic [20:0] exp_route(int code, logic a);
    exp_route = '0;
    if (code >= 1 && code <= 15) exp_route[code-1] = a;
    else if (code == 17) exp_route[15] = a;
    else if (code >= 20 && code <= 24) exp_route[code-4] = a;
  endfunction
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    closed = 0;
    machine_fault = 0;
    speed_dir_fwd = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(66));
    @(posedge pclk);
    #1 chk("no false inhibit", 32'h0, {31'h0, rev});
    // unmapped write first, so the reset reads also show it was ignored
    apb(1, 12'h014, 32'hffff_ffff);
    chk("unmapped werr", 32'h1, {31'h0, err});
    apb(0, FUNC_SEL_ADDR, 0);
    chk("func reset", 32'h4, rd);
    apb(0, POL_SEL_ADDR, 0);
    chk("pol reset", 32'h0, rd);
    apb(0, SRC_SEL_ADDR, 0);
    chk("src reset", 32'h0, rd);
    apb(0, 12'h014, 0);
    chk("unmapped rd", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1, FUNC_SEL_ADDR, 32'hffff_0021);
    apb(0, FUNC_SEL_ADDR, 0);
    chk("func upper", 32'h0021, rd);
    chk("mapped err", 32'h0, {31'h0, err});
    // latency: pin to function takes two sync edges plus routing
    apb(1, FUNC_SEL_ADDR, 32'h1);
    repeat (4) @(posedge pclk);
    closed <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk("enable early", 32'h0, {31'h0, servo_en});
    @(posedge pclk);
    #1 chk("enable on time", 32'h1, {31'h0, servo_en});
    // every selector code with random polarity, source and levels
    for (int code = 0; code <= 33; code++)
    begin
      pol = 1'($urandom);
      src = 1'($urandom);
      virt = 1'($urandom);
      apb(1, FUNC_SEL_ADDR, 32'(code));
      apb(1, POL_SEL_ADDR, {31'h0, pol});
      apb(1, SRC_SEL_ADDR, {31'h0, src});
      apb(1, VIRT_IN_ADDR, {31'h0, virt});
      exp_q.push_back(32'(code));
      exp_q.push_back({31'h0, pol});
      exp_q.push_back({31'h0, src});
      exp_q.push_back({31'h0, virt});
      @(posedge pclk);
      closed <= 1'($urandom);
      speed_dir_fwd <= 1'($urandom);
      repeat (5) @(posedge pclk);
      lvl = src ? virt : ~closed;
      act = pol ? lvl : ~lvl;
      chk("routed", 32'(exp_route(code, act)), 32'(routed));
      chk("estop torque", {31'h0, code == 8 && act}, {31'h0, torque_off});
      chk("force zero", {31'h0, act && ((code == 3 && speed_dir_fwd) ||
          (code == 4 && !speed_dir_fwd))}, {31'h0, speed_force_zero});
      apb(0, STATUS_ADDR, 0);
      chk("status", {30'h0, lvl, act}, rd);
      // read back the four writable words in address order
      for (int ofs = 0; ofs < 16; ofs += 4)
      begin
        apb(0, 12'(ofs), 0);
        chk("readback", exp_q.pop_front(), rd);
        chk("mapped err", 32'h0, {31'h0, err});
      end
    end
    machine_fault <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 chk("fault torque", 32'h1, {31'h0, torque_off});
    apb(0, STATUS_ADDR, 0);
    chk("fault status", 32'h4, rd & 32'h4);
    machine_fault <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 chk("fault gone", 32'h0, {31'h0, torque_off});
    // enable follows the virtual input: raised when it is set, dropped when it clears
    apb(1, FUNC_SEL_ADDR, 32'h1);
    apb(1, SRC_SEL_ADDR, 32'h1);
    apb(1, POL_SEL_ADDR, 32'h1);
    apb(1, VIRT_IN_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    #1 chk("enable raised", 32'h1, {31'h0, servo_en});
    apb(1, VIRT_IN_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    #1 chk("enable dropped", 32'h0, {31'h0, servo_en});
    end_sim();
  end
endmodule // digital_input_channel_router_bench

// ==== verif/terminal_switch_model.sv ====
// external switch wired to the channel terminal, with a pull-up
`timescale 1ns/1ns
module terminal_switch_model
(
  // switch state
  input  wire logic contact_closed,
  // terminal pin
  output logic      pin
);
  // closed contact pulls to ground, open contact leaves the pull-up high
  assign pin = ~contact_closed;
endmodule // terminal_switch_model
